// [psc_defines.svh]
/*
 * Constants of the power-state and phase control block: command codes,
 * register offsets, field positions, reset values and answer codes.
 * Assumes it is included by bare name from the package; the design files rely on that.
 */
`ifndef PSC_DEFINES_SVH
`define PSC_DEFINES_SVH

// Command codes seen on the decoded command port
`define PSC_CMD_VID_FAST     5'h01
`define PSC_CMD_VID_SLOW     5'h02
`define PSC_CMD_SET_PS       5'h05
`define PSC_CMD_SET_REG_PTR  5'h06
`define PSC_CMD_SET_REG_DAT  5'h07
`define PSC_CMD_GET_REG      5'h08

// Register offsets
`define PSC_REG_STATUS       8'h10
`define PSC_REG_VID          8'h31
`define PSC_REG_PS           8'h32
`define PSC_REG_MULTI_VR     8'h34
`define PSC_REG_PTR          8'h35

// Field positions and masks
`define PSC_STATUS_SETTLED   0
`define PSC_MVR_LOCK         1
`define PSC_MVR_WMASK        8'h03
`define PSC_PS_MAX           8'h03

// Reset values
`define PSC_VID_RST          8'h00
`define PSC_PS_RST           3'h0
`define PSC_MVR_RST          8'h00
`define PSC_PTR_RST          8'h00

// Answer codes
`define PSC_ACK_OK           2'h0
`define PSC_ACK_NOT_SUPP     2'h1
`define PSC_ACK_REJECT       2'h3

// Channel count and synchronised analog inputs across all channels
`define PSC_NUM_CH           2
`define PSC_SYNC_W           4

// Clock cycles of the pause after low power is left (3.3 us at 8 ns)
`define PSC_FULL_WAIT_CYC    413

`endif

// [psc_pkg.sv]
/*
 * Types of the power-state and phase control block.
 * Assumes psc_defines.svh is reachable by bare name.
 */
`include "psc_defines.svh"

package psc_pkg;

    // One decoded command from the serial frame decoder
    typedef struct packed {
        logic [4:0] code;     // Command code
        logic       chan;     // Target regulator channel
        logic [7:0] payload;  // Command payload byte
    } psc_cmd_t;

    // Phase and skip configuration of one channel
    typedef struct packed {
        logic ph1;            // Phase 1 enable
        logic ph2;            // Phase 2 enable
        logic ph3;            // Phase 3 enable
        logic skip;           // Pulse skipping enable
    } psc_phase_cfg_t;

endpackage

// [psc_sync.sv]
/*
 * Three-stage synchroniser for pin inputs with an agreement filter.
 * Assumes inputs come from outside the clock domain; output is registered.
 */
`timescale 1ns/1ns
`default_nettype none

module psc_sync
    import psc_pkg::*;
(
    input  wire logic                   clock_i,    // System clock
    input  wire logic                   sys_rst_i,  // Synchronous reset
    input  wire logic [`PSC_SYNC_W-1:0] async_i,    // Raw pin levels
    output logic      [`PSC_SYNC_W-1:0] sync_o      // Filtered levels
);

    logic [`PSC_SYNC_W-1:0] s1_q, s2_q, s3_q;      // Shift stages
    logic [`PSC_SYNC_W-1:0] out_q, out_d;          // Accepted value

    // Accept a bit once stages two and three agree; stage one stays private
    always_comb begin
        out_d = out_q;
        for (int i = 0; i < `PSC_SYNC_W; i++) begin
            if (s2_q[i] == s3_q[i]) begin
                out_d[i] = s3_q[i];
            end
        end
    end

    // Register stages
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            s1_q  <= '0;
            s2_q  <= '0;
            s3_q  <= '0;
            out_q <= '0;
        end else begin
            s1_q  <= async_i;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            out_q <= out_d;
        end
    end

    assign sync_o = out_q;

endmodule // psc_sync

`default_nettype wire

// [psc_ps_decode.sv]
/*
 * Power-state decoder: maps a state code to phase enables and skip.
 * Assumes the state code is held in a register of the caller.
 */
`timescale 1ns/1ns
`default_nettype none

module psc_ps_decode
    import psc_pkg::*;
(
    input  wire logic [2:0]     ps_i,   // Current power state
    output psc_phase_cfg_t      cfg_o   // Resulting configuration
);

    // Table lookup; undefined codes switch nothing on
    always_comb begin
        unique case (ps_i)
            3'h0:    cfg_o = '{ph1: 1'b1, ph2: 1'b1, ph3: 1'b1, skip: 1'b0};
            3'h1:    cfg_o = '{ph1: 1'b1, ph2: 1'b0, ph3: 1'b0, skip: 1'b0};
            3'h2,
            3'h3:    cfg_o = '{ph1: 1'b1, ph2: 1'b0, ph3: 1'b0, skip: 1'b1};
            default: cfg_o = '0;
        endcase
    end

endmodule // psc_ps_decode

`default_nettype wire

// [psc_core.sv]
/*
 * Command interpreter for power states, phase enables and settle alert
 * of a dual-channel core regulator controller.
 * Assumes an external frame decoder delivers one decoded command per
 * strobe and returns the answer code; settle comparators arrive as pins.
 */
`timescale 1ns/1ns
`default_nettype none

module psc_core
    import psc_pkg::*;
(
    input  wire logic                     clock_i,       // 125 MHz clock
    input  wire logic                     sys_rst_i,     // Synchronous reset
    input  wire logic                     cmd_valid_i,   // Command strobe
    input  wire psc_cmd_t                 cmd_i,         // Decoded command
    input  wire logic [`PSC_NUM_CH-1:0]   ramp_done_i,   // Ramp complete pins
    input  wire logic [`PSC_NUM_CH-1:0]   in_window_i,   // Within two steps pins
    output logic                          ack_valid_o,   // Answer strobe
    output logic [1:0]                    ack_code_o,    // Answer code
    output logic [7:0]                    rd_data_o,     // Register read data
    output logic                          alert_n_o,     // Alert, active low
    output psc_phase_cfg_t [`PSC_NUM_CH-1:0] phase_cfg_o, // Phase and skip
    output logic [`PSC_NUM_CH-1:0][7:0]   vid_o          // Voltage target codes
);

    localparam int NCH = `PSC_NUM_CH;

    // Per-channel state
    logic [NCH-1:0][7:0] vid_q, vid_d;       // Voltage code
    logic [NCH-1:0][2:0] ps_q, ps_d;         // Power state
    logic [NCH-1:0][7:0] mvr_q, mvr_d;       // Multi-VR config (lock bit)
    logic [NCH-1:0][7:0] ptr_q, ptr_d;       // Register pointer scratchpad
    logic [NCH-1:0]      pend_q, pend_d;     // Transition awaiting settle
    logic [NCH-1:0]      settled_q, settled_d; // Settled flag
    // Answer path
    logic                ack_valid_q, ack_valid_d;
    logic [1:0]          ack_code_q, ack_code_d;
    logic [7:0]          rd_q, rd_d;
    logic                alert_n_q, alert_n_d;

    logic [`PSC_SYNC_W-1:0] pins_s;          // Synchronised comparators
    logic [NCH-1:0]      done_s, win_s;      // Split per channel

    // Comparator pins come from the analog side
    psc_sync u_sync (
        .clock_i   (clock_i),
        .sys_rst_i (sys_rst_i),
        .async_i   ({in_window_i, ramp_done_i}),
        .sync_o    (pins_s)
    );

    assign done_s = pins_s[NCH-1:0];
    assign win_s  = pins_s[2*NCH-1:NCH];

    // Same decoder per channel
    for (genvar c = 0; c < NCH; c++) begin : g_dec
        psc_ps_decode u_dec (
            .ps_i  (ps_q[c]),
            .cfg_o (phase_cfg_o[c])
        );
    end

    // Command interpretation and settle tracking
    always_comb begin
        logic       hit;
        logic       locked;
        logic       clr_rd;
        hit         = 1'b0;
        locked      = 1'b0;
        clr_rd      = 1'b0;
        vid_d       = vid_q;
        ps_d        = ps_q;
        mvr_d       = mvr_q;
        ptr_d       = ptr_q;
        pend_d      = pend_q;
        settled_d   = settled_q;
        ack_valid_d = 1'b0;
        ack_code_d  = ack_code_q;
        rd_d        = rd_q;
        for (int c = 0; c < NCH; c++) begin
            hit    = cmd_valid_i && (cmd_i.chan == c[0]);
            locked = mvr_q[c][`PSC_MVR_LOCK];
            clr_rd = 1'b0;
            if (hit) begin
                ack_valid_d = 1'b1;
                ack_code_d  = `PSC_ACK_OK;
                unique case (cmd_i.code)
                    `PSC_CMD_VID_FAST,
                    `PSC_CMD_VID_SLOW: begin
                        if (locked) begin
                            ack_code_d = `PSC_ACK_REJECT;
                        end else begin
                            // Only a real change leaves low power
                            if (cmd_i.payload != vid_q[c] && ps_q[c] != 3'h0) begin
                                ps_d[c] = 3'h0;
                            end
                            if (cmd_i.payload != vid_q[c]) begin
                                pend_d[c] = 1'b1;
                            end
                            vid_d[c] = cmd_i.payload;
                        end
                    end
                    `PSC_CMD_SET_PS: begin
                        if (locked) begin
                            ack_code_d = `PSC_ACK_REJECT;
                        end else if (cmd_i.payload > `PSC_PS_MAX) begin
                            ack_code_d = `PSC_ACK_REJECT;
                        end else begin
                            ps_d[c] = cmd_i.payload[2:0];
                        end
                    end
                    `PSC_CMD_SET_REG_PTR: begin
                        ptr_d[c] = cmd_i.payload;
                    end
                    `PSC_CMD_SET_REG_DAT: begin
                        // Only the configuration register is writable here
                        if (ptr_q[c] == `PSC_REG_MULTI_VR) begin
                            mvr_d[c] = cmd_i.payload & `PSC_MVR_WMASK;
                        end else begin
                            ack_code_d = `PSC_ACK_NOT_SUPP;
                        end
                    end
                    `PSC_CMD_GET_REG: begin
                        unique case (cmd_i.payload)
                            `PSC_REG_STATUS: begin
                                rd_d   = {7'h00, settled_q[c]};
                                clr_rd = 1'b1;
                            end
                            `PSC_REG_VID:      rd_d = vid_q[c];
                            `PSC_REG_PS:       rd_d = 8'h01 << ps_q[c];
                            `PSC_REG_MULTI_VR: rd_d = mvr_q[c];
                            `PSC_REG_PTR:      rd_d = ptr_q[c];
                            default: begin
                                rd_d       = 8'h00;
                                ack_code_d = `PSC_ACK_NOT_SUPP;
                            end
                        endcase
                    end
                    default: begin
                        ack_code_d = `PSC_ACK_NOT_SUPP;
                    end
                endcase
            end
            // Read clears; a settle in the same cycle wins
            if (clr_rd) begin
                settled_d[c] = 1'b0;
            end
            if (pend_q[c] && done_s[c] && win_s[c]) begin
                settled_d[c] = 1'b1;
                pend_d[c]    = 1'b0;
            end
        end
        alert_n_d = ~(|settled_d);
    end

    // Register all state
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            for (int c = 0; c < NCH; c++) begin
                vid_q[c] <= `PSC_VID_RST;
                ps_q[c]  <= `PSC_PS_RST;
                mvr_q[c] <= `PSC_MVR_RST;
                ptr_q[c] <= `PSC_PTR_RST;
            end
            pend_q      <= '0;
            settled_q   <= '0;
            ack_valid_q <= 1'b0;
            ack_code_q  <= `PSC_ACK_OK;
            rd_q        <= 8'h00;
            alert_n_q   <= 1'b1;
        end else begin
            vid_q       <= vid_d;
            ps_q        <= ps_d;
            mvr_q       <= mvr_d;
            ptr_q       <= ptr_d;
            pend_q      <= pend_d;
            settled_q   <= settled_d;
            ack_valid_q <= ack_valid_d;
            ack_code_q  <= ack_code_d;
            rd_q        <= rd_d;
            alert_n_q   <= alert_n_d;
        end
    end

    // Outputs straight from flops
    assign ack_valid_o = ack_valid_q;
    assign ack_code_o  = ack_code_q;
    assign rd_data_o   = rd_q;
    assign alert_n_o   = alert_n_q;
    assign vid_o       = vid_q;

    // Checks on channel 0 commands, settle tracking and the phase table
    logic c0;
    assign c0 = cmd_valid_i && !cmd_i.chan;

    sequence s_ptr_write;
        c0 && cmd_i.code == `PSC_CMD_SET_REG_PTR;
    endsequence

    sequence s_locked_cmd;
        c0 && mvr_q[0][`PSC_MVR_LOCK] &&
        (cmd_i.code == `PSC_CMD_SET_PS || cmd_i.code == `PSC_CMD_VID_FAST ||
         cmd_i.code == `PSC_CMD_VID_SLOW);
    endsequence

    sequence s_vid_change_lp;
        c0 && !mvr_q[0][`PSC_MVR_LOCK] && ps_q[0] != 3'h0 &&
        (cmd_i.code == `PSC_CMD_VID_FAST || cmd_i.code == `PSC_CMD_VID_SLOW) &&
        cmd_i.payload != vid_q[0];
    endsequence

    sequence s_settle_cause;
        pend_q[0] && done_s[0] && win_s[0];
    endsequence

    property p_ptr_capture;
        @(posedge clock_i) disable iff (sys_rst_i)
        s_ptr_write |=> ptr_q[0] == $past(cmd_i.payload);
    endproperty
    a_ptr_capture: assert property (p_ptr_capture) else $error("pointer not captured");

    property p_lock_reject;
        @(posedge clock_i) disable iff (sys_rst_i)
        s_locked_cmd |=> ack_valid_o && ack_code_o == `PSC_ACK_REJECT && $stable(ps_q[0]) && $stable(vid_q[0]);
    endproperty
    a_lock_reject: assert property (p_lock_reject) else $error("locked command accepted");

    property p_bad_ps;
        @(posedge clock_i) disable iff (sys_rst_i)
        c0 && cmd_i.code == `PSC_CMD_SET_PS && !mvr_q[0][`PSC_MVR_LOCK] && cmd_i.payload > `PSC_PS_MAX
        |=> ack_code_o == `PSC_ACK_REJECT && $stable(ps_q[0]);
    endproperty
    a_bad_ps: assert property (p_bad_ps) else $error("unsupported state accepted");

    property p_auto_full;
        @(posedge clock_i) disable iff (sys_rst_i)
        s_vid_change_lp |=> ps_q[0] == 3'h0 ##0 phase_cfg_o[0] == 4'b1110;
    endproperty
    a_auto_full: assert property (p_auto_full) else $error("no return to full power");

    property p_ps_indep;
        @(posedge clock_i) disable iff (sys_rst_i)
        c0 && cmd_i.code == `PSC_CMD_SET_PS |=> $stable(vid_q[0]);
    endproperty
    a_ps_indep: assert property (p_ps_indep) else $error("state command moved voltage");

    property p_cfg_map;
        @(posedge clock_i) disable iff (sys_rst_i)
        ps_q[1] == ps_q[0] |-> phase_cfg_o[1] == phase_cfg_o[0] &&
        (ps_q[0] != 3'h1 || phase_cfg_o[0] == 4'b1000) &&
        (ps_q[0] < 3'h2 || ps_q[0] > 3'h3 || phase_cfg_o[0] == 4'b1001);
    endproperty
    a_cfg_map: assert property (p_cfg_map) else $error("phase table mismatch");

    property p_settle;
        @(posedge clock_i) disable iff (sys_rst_i)
        s_settle_cause |=> settled_q[0] && !alert_n_o && !pend_q[0];
    endproperty
    a_settle: assert property (p_settle) else $error("settle not flagged");

    property p_no_early;
        @(posedge clock_i) disable iff (sys_rst_i)
        $rose(settled_q[0]) |-> $past(done_s[0]) && $past(win_s[0]);
    endproperty
    a_no_early: assert property (p_no_early) else $error("settled before window");

    property p_read_clear;
        @(posedge clock_i) disable iff (sys_rst_i)
        c0 && cmd_i.code == `PSC_CMD_GET_REG && cmd_i.payload == `PSC_REG_STATUS &&
        !(pend_q[0] && done_s[0] && win_s[0]) && !settled_q[1]
        |=> !settled_q[0] && alert_n_o;
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("status read did not clear");

    // Full power must light all three phases with skipping off
    property p_full_map;
        @(posedge clock_i) disable iff (sys_rst_i)
        ps_q[0] == 3'h0 |-> phase_cfg_o[0] == 4'b1110;
    endproperty
    a_full_map: assert property (p_full_map) else $error("full power phases wrong");

    // A data write lands in the multi-VR register when the pointer names it
    property p_data_write;
        @(posedge clock_i) disable iff (sys_rst_i)
        c0 && cmd_i.code == `PSC_CMD_SET_REG_DAT && ptr_q[0] == `PSC_REG_MULTI_VR
        |=> mvr_q[0] == ($past(cmd_i.payload) & `PSC_MVR_WMASK) && ack_code_o == `PSC_ACK_OK;
    endproperty
    a_data_write: assert property (p_data_write) else $error("data write missed pointer");

endmodule // psc_core

`default_nettype wire

// [psc_cpu_model.sv]
/*
 * Command master model for the power-state block: it presents one
 * decoded command per clock edge on behalf of the CPU.
 * Assumes callers run on the rising clock edge and drive by non-blocking
 * assignment.
 */
`timescale 1ns/1ns
`default_nettype none

module psc_cpu_model
    import psc_pkg::*;
(
    input  wire logic clock_i,      // System clock
    output logic      cmd_valid_o,  // Command strobe
    output psc_cmd_t  cmd_o         // Decoded command
);
    // Quiet bus at time zero
    initial begin
        cmd_valid_o = 1'b0;
        cmd_o       = '0;
    end

    // Present one command for exactly one edge; strobe held for back to back
    task automatic issue(input psc_cmd_t c);
        cmd_valid_o <= 1'b1;
        cmd_o       <= c;
        @(posedge clock_i);
    endtask

    // Release the strobe; the whole command is flipped so stale data is never trusted
    task automatic idle();
        cmd_valid_o <= 1'b0;
        cmd_o       <= ~cmd_o;
        @(posedge clock_i);
    endtask

    // Pause after low power was left, before full-power operation
    task automatic full_power_wait();
        repeat (`PSC_FULL_WAIT_CYC) idle();
    endtask
endmodule // psc_cpu_model
`default_nettype wire

// [psc_core_test.sv]
/*
 * Self-checking bench of the power-state block: states, voltage, settle
 * alert, pointer writes and lock.
 * Assumes psc_pkg, psc_defines.svh and psc_cpu_model are compiled first.
 */
`timescale 1ns/1ns
`default_nettype none

module psc_core_test
    import psc_pkg::*;
;
    typedef struct {
        logic [1:0] code;  // Expected answer code
        logic [7:0] mask;  // Read bits that matter
        logic [7:0] rd;    // Expected read data
    } psc_exp_t;

    logic                 clock_i = 1'b0;   // 125 MHz clock
    logic                 sys_rst_i = 1'b1; // Reset held at start
    logic                 cmd_valid_i;      // From the master model
    psc_cmd_t             cmd_i;            // From the master model
    logic [1:0]           ramp_done_i = '0; // Analog ramp pins
    logic [1:0]           in_window_i = '0; // Analog window pins
    logic                 ack_valid_o;      // Answer strobe
    logic [1:0]           ack_code_o;       // Answer code
    logic [7:0]           rd_data_o;        // Read data
    logic                 alert_n_o;        // Alert, active low
    psc_phase_cfg_t [1:0] phase_cfg_o;      // Phase and skip per channel
    logic [1:0][7:0]      vid_o;            // Voltage codes
    int                   n_errors = 0;     // Mismatches
    int                   samples_checked = 0; // Comparisons
    psc_exp_t             exp_q[$];         // Pending answers
    logic [2:0]           cur;              // Model of the state
    logic [7:0]           v;                // Random voltage code
    int                   k;                // Loop index

    // Free-running clock, 8 ns period
    always #4 clock_i = ~clock_i;

    psc_core DUT (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i),
        .ramp_done_i(ramp_done_i), .in_window_i(in_window_i), .ack_valid_o(ack_valid_o),
        .ack_code_o(ack_code_o), .rd_data_o(rd_data_o), .alert_n_o(alert_n_o),
        .phase_cfg_o(phase_cfg_o), .vid_o(vid_o));

    psc_cpu_model u_cpu (.clock_i(clock_i), .cmd_valid_o(cmd_valid_i), .cmd_o(cmd_i));

    // Single comparison point
    task automatic check(input logic [7:0] seen, input logic [7:0] want, input string what);
        samples_checked++;
        if (seen !== want) begin
            n_errors++;
            $display("Error at %0t: %s seen %h expected %h", $time, what, seen, want);
        end
    endtask

    // Verdict and end of run
    task automatic summarize();
        $display("Checked %0d, errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Note the answer expected, then hand the command to the master
    task automatic cmd(input logic [4:0] c, input logic ch, input logic [7:0] pl, input logic [1:0] ec,
                       input logic [7:0] m = 8'h00, input logic [7:0] rd = 8'h00);
        exp_q.push_back('{ec, m, rd});
        u_cpu.issue('{c, ch, pl});
    endtask

    // Phase and skip expected for a state; codes above 3 enable nothing
    function automatic psc_phase_cfg_t cfg_of(input logic [2:0] ps);
        case (ps)
            3'h0: cfg_of = 4'b1110;
            3'h1: cfg_of = 4'b1000;
            3'h2, 3'h3: cfg_of = 4'b1001;
            default: cfg_of = 4'b0000;
        endcase
    endfunction

    // Compare one channel's phase outputs with the modelled state
    task automatic ps_chk(input logic ch, input logic [2:0] ps);
        check({4'h0, phase_cfg_o[ch]}, {4'h0, cfg_of(ps)}, "phase config");
    endtask

    // Monitor: every answer consumes the oldest note
    always @(posedge clock_i) begin : mon
        psc_exp_t e;
        if (ack_valid_o === 1'b1) begin
            if (exp_q.size() == 0) begin
                check(8'h01, 8'h00, "answer without command");
            end else begin
                e = exp_q.pop_front();
                check({6'h0, ack_code_o}, {6'h0, e.code}, "answer code");
                check(rd_data_o & e.mask, e.rd, "read data");
            end
        end
    end

    // Main sequence
    initial begin
        void'($urandom(43811));
        repeat (5) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        u_cpu.idle();
        check({7'h0, alert_n_o}, 8'h01, "alert after reset");
        check(vid_o[1], 8'h00, "voltage after reset");
        // Every state code on both channels, each read back at once
        for (k = 0; k < 16; k++) begin
            cur = (k[2:0] > 3'h3) ? 3'h3 : k[2:0];
            cmd(`PSC_CMD_SET_PS, k[3], {5'h0, k[2:0]}, (k[2:0] > 3'h3) ? `PSC_ACK_REJECT : `PSC_ACK_OK);
            cmd(`PSC_CMD_GET_REG, k[3], `PSC_REG_PS, `PSC_ACK_OK, 8'hff, 8'h01 << cur);
            u_cpu.idle();
            ps_chk(k[3], cur);
        end
        $display("Test power states done");
        // Output-changing voltage leaves low power; same value does not
        v = 8'($urandom_range(1, 254));
        cmd(`PSC_CMD_SET_PS, 1'b0, 8'h02, `PSC_ACK_OK);
        cmd(`PSC_CMD_VID_FAST, 1'b0, v, `PSC_ACK_OK);
        cmd(`PSC_CMD_GET_REG, 1'b0, `PSC_REG_PS, `PSC_ACK_OK, 8'hff, 8'h01);
        u_cpu.idle();
        ps_chk(1'b0, 3'h0);
        check(vid_o[0], v, "voltage code");
        u_cpu.full_power_wait();
        cmd(`PSC_CMD_SET_PS, 1'b0, 8'h03, `PSC_ACK_OK);
        cmd(`PSC_CMD_VID_SLOW, 1'b0, v, `PSC_ACK_OK);
        u_cpu.idle();
        ps_chk(1'b0, 3'h3);
        check(vid_o[0], v, "voltage kept");
        ps_chk(1'b1, 3'h3);
        check(vid_o[1], 8'h00, "other channel voltage");
        $display("Test voltage and state done");
        // Settle needs both pins; flag and alert stay until status read
        v = v ^ 8'h81;
        cmd(`PSC_CMD_VID_SLOW, 1'b0, v, `PSC_ACK_OK);
        u_cpu.idle();
        ps_chk(1'b0, 3'h0);
        ramp_done_i <= 2'b01;
        repeat (12) u_cpu.idle();
        check({7'h0, alert_n_o}, 8'h01, "alert on ramp only");
        in_window_i <= 2'b01;
        for (k = 0; k < 20 && alert_n_o !== 1'b0; k++) u_cpu.idle();
        check({7'h0, alert_n_o}, 8'h00, "alert after settle");
        if (alert_n_o !== 1'b0) summarize();
        ramp_done_i <= 2'b00;
        in_window_i <= 2'b00;
        repeat (8) u_cpu.idle();
        check({7'h0, alert_n_o}, 8'h00, "alert held");
        cmd(`PSC_CMD_GET_REG, 1'b0, `PSC_REG_STATUS, `PSC_ACK_OK, 8'h01, 8'h01);
        u_cpu.idle();
        u_cpu.idle();
        check({7'h0, alert_n_o}, 8'h01, "alert after read");
        cmd(`PSC_CMD_GET_REG, 1'b0, `PSC_REG_STATUS, `PSC_ACK_OK, 8'h01, 8'h00);
        $display("Test settle alert done");
        // Pointer scratchpad, lock and refusals
        cmd(`PSC_CMD_SET_REG_PTR, 1'b0, `PSC_REG_VID, `PSC_ACK_OK);
        cmd(`PSC_CMD_SET_REG_DAT, 1'b0, 8'h77, `PSC_ACK_NOT_SUPP);
        cmd(`PSC_CMD_GET_REG, 1'b0, `PSC_REG_PTR, `PSC_ACK_OK, 8'hff, `PSC_REG_VID);
        cmd(`PSC_CMD_SET_REG_PTR, 1'b0, `PSC_REG_MULTI_VR, `PSC_ACK_OK);
        cmd(`PSC_CMD_SET_REG_DAT, 1'b0, 8'h02, `PSC_ACK_OK);
        cmd(`PSC_CMD_GET_REG, 1'b0, `PSC_REG_MULTI_VR, `PSC_ACK_OK, 8'hff, 8'h02);
        cmd(`PSC_CMD_VID_FAST, 1'b0, ~v, `PSC_ACK_REJECT);
        cmd(`PSC_CMD_VID_SLOW, 1'b0, ~v, `PSC_ACK_REJECT);
        cmd(`PSC_CMD_SET_PS, 1'b0, 8'h01, `PSC_ACK_REJECT);
        u_cpu.idle();
        check(vid_o[0], v, "voltage under lock");
        ps_chk(1'b0, 3'h0);
        cmd(`PSC_CMD_GET_REG, 1'b0, `PSC_REG_VID, `PSC_ACK_OK, 8'hff, v);
        cmd(`PSC_CMD_SET_REG_DAT, 1'b0, 8'h00, `PSC_ACK_OK);
        cmd(`PSC_CMD_SET_PS, 1'b0, 8'h01, `PSC_ACK_OK);
        cmd(5'h1f, 1'b0, 8'h00, `PSC_ACK_NOT_SUPP);
        cmd(`PSC_CMD_GET_REG, 1'b0, 8'h7e, `PSC_ACK_NOT_SUPP, 8'hff, 8'h00);
        u_cpu.idle();
        ps_chk(1'b0, 3'h1);
        $display("Test pointer and lock done");
        // Drain outstanding answers under a bound
        for (k = 0; k < 10 && exp_q.size() > 0; k++) u_cpu.idle();
        check(8'(exp_q.size()), 8'h00, "answers missing");
        summarize();
    end
endmodule // psc_core_test
`default_nettype wire
